// [cvj_pkg.sv]
package cvj_pkg;
    // ---------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_LDAC = 6'h0B;
    localparam logic [5:0] IDX_RDAC = 6'h0C;
    localparam logic [5:0] IDX_JACK = 6'h0D;
    localparam logic [5:0] IDX_ADCC = 6'h0E;
    localparam logic [5:0] IDX_LADC = 6'h0F;
    localparam logic [5:0] IDX_RADC = 6'h10;
    localparam logic [5:0] IDX_JCFG = 6'h20;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [8:0] RST_VOL  = 9'h0FF;
    localparam logic [8:0] RST_JACK = 9'h000;
    localparam logic [8:0] RST_ADCC = 9'h100;
    localparam logic [8:0] RST_JCFG = 9'h000;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int VU_BIT     = 8;
    localparam int HPF_EN_BIT = 8;
    localparam int HPF_MD_BIT = 7;
    localparam int HPF_SEL_LO = 4;
    localparam int OSR_BIT    = 3;
    localparam int RINV_BIT   = 1;
    localparam int LINV_BIT   = 0;
    localparam int JCK_HI_LO  = 4;
    localparam int JCK_LO_LO  = 0;
    localparam int JDET_EN    = 0;
    // ---------------------------------------------------------------
    // filter shifts and bus answers
    // ---------------------------------------------------------------
    localparam logic [4:0] K_DC       = 5'h0B;
    localparam logic [4:0] K_APP_BASE = 5'h0A;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;
    localparam int         SMP_W      = 24;

    typedef struct packed {
        logic [7:0] left;
        logic [7:0] right;
    } cvj_gain_pair_s;

    typedef struct packed {
        logic aux1;
        logic aux2;
        logic spk;
        logic hp;
    } cvj_drv_s;

    typedef struct packed {
        logic             valid;
        logic [SMP_W-1:0] left;
        logic [SMP_W-1:0] right;
    } cvj_smp_s;
endpackage

// [cvj_regs.sv]
// Added by the designer: register access over AXI4-Lite.
module cvj_regs
    import cvj_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              CLK_SYS_I,
    input  wire logic              RSTN_I,
    input  wire logic [ADDR_W-1:0] AWADDR_I,
    input  wire logic              AWVALID_I,
    output logic                   AWREADY_O,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic [3:0]        WSTRB_I,
    input  wire logic              WVALID_I,
    output logic                   WREADY_O,
    output logic [1:0]             BRESP_O,
    output logic                   BVALID_O,
    input  wire logic              BREADY_I,
    input  wire logic [ADDR_W-1:0] ARADDR_I,
    input  wire logic              ARVALID_I,
    output logic                   ARREADY_O,
    output logic [31:0]            RDATA_O,
    output logic [1:0]             RRESP_O,
    output logic                   RVALID_O,
    input  wire logic              RREADY_I,
    input  wire logic              JACK_DET_I,
    input  wire cvj_smp_s          ADC_SMP_I,
    output cvj_smp_s               ADC_SMP_O,
    output cvj_gain_pair_s         DAC_GAIN_O,
    output cvj_gain_pair_s         ADC_GAIN_O,
    output logic [1:0]             DAC_MUTE_O,
    output logic [1:0]             ADC_MUTE_O,
    output cvj_drv_s               DRV_EN_O,
    output logic                   ADC_OSR128_O
);
    // ---------------------------------------------------------------
    // register view
    // ---------------------------------------------------------------
    cvj_gain_pair_s    stg_dac_r, stg_dac_nxt, act_dac_r, act_dac_nxt;
    cvj_gain_pair_s    stg_adc_r, stg_adc_nxt, act_adc_r, act_adc_nxt;
    logic [8:0]        jack_r, jack_nxt, adcc_r, adcc_nxt;
    logic [8:0]        jcfg_r, jcfg_nxt;

    function automatic logic [9:0] reg_view(input logic [5:0] idx);
        unique case (idx)
            IDX_LDAC: reg_view = {2'b10, stg_dac_r.left};
            IDX_RDAC: reg_view = {2'b10, stg_dac_r.right};
            IDX_JACK: reg_view = {1'b1, jack_r};
            IDX_ADCC: reg_view = {1'b1, adcc_r};
            IDX_LADC: reg_view = {2'b10, stg_adc_r.left};
            IDX_RADC: reg_view = {2'b10, stg_adc_r.right};
            IDX_JCFG: reg_view = {1'b1, jcfg_r};
            default:  reg_view = 10'h000;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [5:0]        wr_idx_r, wr_idx_nxt, rd_idx_r, rd_idx_nxt;
    logic [31:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [3:0]        wstrb_r, wstrb_nxt;
    logic              wr_fire;
    logic [9:0]        wr_old, rd_view;
    logic [8:0]        wr_val;

    assign AWREADY_O = !aw_hold_r && !bvalid_r;
    assign WREADY_O  = !w_hold_r && !bvalid_r;
    assign ARREADY_O = !rvalid_r;
    assign BVALID_O  = bvalid_r;
    assign BRESP_O   = bresp_r;
    assign RVALID_O  = rvalid_r;
    assign RRESP_O   = rresp_r;
    assign RDATA_O   = rdata_r;
    // write acts once both address and data are held
    assign wr_fire   = aw_hold_r && w_hold_r;
    // function reads register state, so keep it in a process
    always_comb begin
        wr_old  = reg_view(wr_idx_r);
        rd_view = reg_view(ARADDR_I[7:2]);
    end
    // unstrobed lanes keep the old value; update bit then reads as 0
    assign wr_val    = {wstrb_r[1] ? wdata_r[8] : wr_old[8],
                        wstrb_r[0] ? wdata_r[7:0] : wr_old[7:0]};

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        wr_idx_nxt  = wr_idx_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r && !BREADY_I;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r && !RREADY_I;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        rd_idx_nxt  = rd_idx_r;
        if (AWVALID_I && AWREADY_O) begin
            aw_hold_nxt = 1'b1;
            wr_idx_nxt  = AWADDR_I[7:2];
        end
        if (WVALID_I && WREADY_O) begin
            w_hold_nxt = 1'b1;
            wdata_nxt  = WDATA_I;
            wstrb_nxt  = WSTRB_I;
        end
        if (wr_fire) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_old[9] ? RESP_OKAY : RESP_SLV;
        end
        if (ARVALID_I && ARREADY_O) begin
            rvalid_nxt = 1'b1;
            rd_idx_nxt = ARADDR_I[7:2];
            rdata_nxt  = {23'h000000, rd_view[8:0]};
            rresp_nxt  = rd_view[9] ? RESP_OKAY : RESP_SLV;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            rvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rresp_r   <= RESP_OKAY;
            wr_idx_r  <= 6'h00;
            rd_idx_r  <= 6'h00;
            wdata_r   <= 32'h00000000;
            rdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            bvalid_r  <= bvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            bresp_r   <= bresp_nxt;
            rresp_r   <= rresp_nxt;
            wr_idx_r  <= wr_idx_nxt;
            rd_idx_r  <= rd_idx_nxt;
            wdata_r   <= wdata_nxt;
            rdata_r   <= rdata_nxt;
            wstrb_r   <= wstrb_nxt;
        end
    end

    // ---------------------------------------------------------------
    // control registers and paired volume staging
    // ---------------------------------------------------------------
    always_comb begin
        stg_dac_nxt = stg_dac_r;
        act_dac_nxt = act_dac_r;
        stg_adc_nxt = stg_adc_r;
        act_adc_nxt = act_adc_r;
        jack_nxt    = jack_r;
        adcc_nxt    = adcc_r;
        jcfg_nxt    = jcfg_r;
        if (wr_fire) begin
            case (wr_idx_r)
                IDX_LDAC: begin
                    stg_dac_nxt.left = wr_val[7:0];
                    if (wr_val[VU_BIT]) begin
                        act_dac_nxt.left  = wr_val[7:0];
                        act_dac_nxt.right = stg_dac_r.right;
                    end
                end
                IDX_RDAC: begin
                    stg_dac_nxt.right = wr_val[7:0];
                    if (wr_val[VU_BIT]) begin
                        act_dac_nxt.right = wr_val[7:0];
                        act_dac_nxt.left  = stg_dac_r.left;
                    end
                end
                IDX_JACK: jack_nxt = wr_val;
                IDX_ADCC: adcc_nxt = wr_val;
                IDX_LADC: begin
                    stg_adc_nxt.left = wr_val[7:0];
                    if (wr_val[VU_BIT]) begin
                        act_adc_nxt.left  = wr_val[7:0];
                        act_adc_nxt.right = stg_adc_r.right;
                    end
                end
                IDX_RADC: begin
                    stg_adc_nxt.right = wr_val[7:0];
                    if (wr_val[VU_BIT]) begin
                        act_adc_nxt.right = wr_val[7:0];
                        act_adc_nxt.left  = stg_adc_r.left;
                    end
                end
                IDX_JCFG: jcfg_nxt = wr_val;
                default:  jcfg_nxt = jcfg_r;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            stg_dac_r <= {RST_VOL[7:0], RST_VOL[7:0]};
            act_dac_r <= {RST_VOL[7:0], RST_VOL[7:0]};
            stg_adc_r <= {RST_VOL[7:0], RST_VOL[7:0]};
            act_adc_r <= {RST_VOL[7:0], RST_VOL[7:0]};
            jack_r    <= RST_JACK;
            adcc_r    <= RST_ADCC;
            jcfg_r    <= RST_JCFG;
        end else begin
            stg_dac_r <= stg_dac_nxt;
            act_dac_r <= act_dac_nxt;
            stg_adc_r <= stg_adc_nxt;
            act_adc_r <= act_adc_nxt;
            jack_r    <= jack_nxt;
            adcc_r    <= adcc_nxt;
            jcfg_r    <= jcfg_nxt;
        end
    end

    assign DAC_GAIN_O   = act_dac_r;
    assign ADC_GAIN_O   = act_adc_r;
    assign ADC_OSR128_O = adcc_r[OSR_BIT];

    // ---------------------------------------------------------------
    // mute decode and jack driven enables
    // ---------------------------------------------------------------
    logic [1:0]        dmute_r, dmute_nxt, amute_r, amute_nxt;
    logic              jd_s1_r, jd_s2_r;
    logic [3:0]        drv_r, drv_nxt;

    always_comb begin
        dmute_nxt = {act_dac_r.left == 8'h00, act_dac_r.right == 8'h00};
        amute_nxt = {act_adc_r.left == 8'h00, act_adc_r.right == 8'h00};
        drv_nxt   = 4'h0;
        if (jcfg_r[JDET_EN]) begin
            // pick enable nibble by jack level
            drv_nxt = jd_s2_r ? jack_r[JCK_HI_LO +: 4]
                              : jack_r[JCK_LO_LO +: 4];
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            dmute_r <= 2'h0;
            amute_r <= 2'h0;
            jd_s1_r <= 1'b0;
            jd_s2_r <= 1'b0;
            drv_r   <= 4'h0;
        end else begin
            dmute_r <= dmute_nxt;
            amute_r <= amute_nxt;
            jd_s1_r <= JACK_DET_I;
            jd_s2_r <= jd_s1_r;
            drv_r   <= drv_nxt;
        end
    end

    assign DAC_MUTE_O = dmute_r;
    assign ADC_MUTE_O = amute_r;
    assign DRV_EN_O   = drv_r;

    // ---------------------------------------------------------------
    // record path: polarity and high-pass
    // ---------------------------------------------------------------
    // leaky dc estimate per stage; mode 1 cascades two for 2nd order
    function automatic logic [SMP_W-1:0] sat(input logic [SMP_W:0] v);
        if (v[SMP_W] != v[SMP_W-1]) begin
            sat = {v[SMP_W], {(SMP_W-1){!v[SMP_W]}}};
        end else begin
            sat = v[SMP_W-1:0];
        end
    endfunction

    logic [4:0]        k_one, k_two;
    logic              smp_v_r;
    logic [SMP_W-1:0]  smp_out [2];

    // cutoff select only steers mode 1
    assign k_one = adcc_r[HPF_MD_BIT]
                 ? K_APP_BASE - {2'h0, adcc_r[HPF_SEL_LO +: 3]} : K_DC;
    assign k_two = k_one;

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic signed [31:0]      dc1_r, dc1_nxt, dc2_r, dc2_nxt;
        logic        [SMP_W-1:0] y_r, y_nxt, x, xi, y1, y2;
        logic signed [32:0]      d1, d2;
        logic                    inv;

        assign x   = ch ? ADC_SMP_I.left : ADC_SMP_I.right;
        assign inv = ch ? adcc_r[LINV_BIT] : adcc_r[RINV_BIT];

        always_comb begin
            // sign inversion, saturating the most negative
            xi = inv ? sat(-{x[SMP_W-1], x}) : x;
            d1 = {xi[SMP_W-1], xi, 8'h00} - {dc1_r[31], dc1_r};
            y1 = sat({xi[SMP_W-1], xi} - {dc1_r[31], dc1_r[31:8]});
            d2 = {y1[SMP_W-1], y1, 8'h00} - {dc2_r[31], dc2_r};
            y2 = sat({y1[SMP_W-1], y1} - {dc2_r[31], dc2_r[31:8]});
            dc1_nxt = dc1_r;
            dc2_nxt = dc2_r;
            y_nxt   = y_r;
            if (ADC_SMP_I.valid) begin
                if (adcc_r[HPF_EN_BIT]) begin
                    // only the difference is scaled, signed
                    dc1_nxt = dc1_r + 32'(d1 >>> k_one);
                    if (adcc_r[HPF_MD_BIT]) begin
                        dc2_nxt = dc2_r + 32'(d2 >>> k_two);
                    end
                    y_nxt = adcc_r[HPF_MD_BIT] ? y2 : y1;
                end else begin
                    y_nxt = xi;
                end
            end
            if (!adcc_r[HPF_EN_BIT]) begin
                dc1_nxt = 32'sh0;
            end
            if (!adcc_r[HPF_EN_BIT] || !adcc_r[HPF_MD_BIT]) begin
                dc2_nxt = 32'sh0;
            end
        end

        always_ff @(posedge CLK_SYS_I) begin
            if (!RSTN_I) begin
                dc1_r <= 32'sh0;
                dc2_r <= 32'sh0;
                y_r   <= '0;
            end else begin
                dc1_r <= dc1_nxt;
                dc2_r <= dc2_nxt;
                y_r   <= y_nxt;
            end
        end
        assign smp_out[ch] = y_r;
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            smp_v_r <= 1'b0;
        end else begin
            smp_v_r <= ADC_SMP_I.valid;
        end
    end

    assign ADC_SMP_O = {smp_v_r, smp_out[1], smp_out[0]};

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    logic wr_rdac, wr_ldac, wr_ladc, wr_radc;
    assign wr_rdac = wr_fire && wr_idx_r == IDX_RDAC;
    assign wr_ldac = wr_fire && wr_idx_r == IDX_LDAC;
    assign wr_ladc = wr_fire && wr_idx_r == IDX_LADC;
    assign wr_radc = wr_fire && wr_idx_r == IDX_RADC;

    a_rdac_stage: assert property (
        wr_rdac && !wr_val[VU_BIT] |=> $stable(act_dac_r)
            && stg_dac_r.right == $past(wr_val[7:0]))
        else $error("right play gain moved without update");
    a_rdac_commit: assert property (
        wr_rdac && wr_val[VU_BIT] |=> act_dac_r.right == $past(wr_val[7:0])
            && act_dac_r.left == $past(stg_dac_r.left))
        else $error("right play update did not commit pair");
    a_vol_readback: assert property (
        RVALID_O && rd_idx_r == IDX_RDAC |-> RDATA_O[31:8] == 24'h000000)
        else $error("volume update bit read back as one");
    a_mute_decode: assert property (
        wr_rdac && wr_val[VU_BIT] && wr_val[7:0] == 8'h00 |=> ##1
            DAC_MUTE_O[0])
        else $error("zero play gain not muted");
    a_jack_high: assert property (
        jcfg_r[JDET_EN] && jd_s2_r |=> DRV_EN_O == $past(jack_r[7:4]))
        else $error("jack high enables wrong");
    a_jack_low: assert property (
        jcfg_r[JDET_EN] && !jd_s2_r |=> DRV_EN_O == $past(jack_r[3:0]))
        else $error("jack low enables wrong");
    a_hpf_bypass: assert property (
        ADC_SMP_I.valid && !adcc_r[HPF_EN_BIT] && !adcc_r[RINV_BIT]
            |=> ADC_SMP_O.right == $past(ADC_SMP_I.right))
        else $error("bypass altered right sample");
    a_left_invert: assert property (
        ADC_SMP_I.valid && !adcc_r[HPF_EN_BIT] && adcc_r[LINV_BIT]
            && ADC_SMP_I.left != 24'h800000
            |=> ADC_SMP_O.left == 24'(-$past(ADC_SMP_I.left)))
        else $error("left record sign not inverted");
    a_osr_follow: assert property (
        wr_fire && wr_idx_r == IDX_ADCC |=> ADC_OSR128_O
            == $past(wr_val[OSR_BIT]))
        else $error("oversample select not applied");
    a_ladc_stage: assert property (
        wr_ladc && !wr_val[VU_BIT] |=> $stable(act_adc_r))
        else $error("left record gain moved without update");
    a_ladc_commit: assert property (
        wr_ladc && wr_val[VU_BIT] |=> act_adc_r.left == $past(wr_val[7:0])
            && act_adc_r.right == $past(stg_adc_r.right))
        else $error("left record update did not commit pair");
    a_ldac_commit: assert property (
        wr_ldac && wr_val[VU_BIT] |=> act_dac_r.right
            == $past(stg_dac_r.right))
        else $error("left play update lost pending right");
    a_radc_commit: assert property (
        wr_radc && wr_val[VU_BIT] |=> act_adc_r.left
            == $past(stg_adc_r.left))
        else $error("right record update lost pending left");

    c_rdac_commit: cover property (wr_rdac && wr_val[VU_BIT]);
    c_jack_high:   cover property (jcfg_r[JDET_EN] && jd_s2_r ##1 |DRV_EN_O);
    c_hpf_mode1:   cover property (ADC_SMP_I.valid && adcc_r[HPF_MD_BIT]
                                   && adcc_r[HPF_EN_BIT]);
    c_bad_read:    cover property (RVALID_O && RRESP_O == RESP_SLV);
endmodule // cvj_regs

// [testbench.sv]
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
    n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end

module testbench import cvj_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic           clk = 1'b0;
    logic           rstn = 1'b0;
    logic [7:0]     awaddr = 8'h00;
    logic [7:0]     araddr = 8'h00;
    logic           awvalid = 1'b0;
    logic           wvalid = 1'b0;
    logic           arvalid = 1'b0;
    logic [31:0]    wdata = 32'h0;
    logic           jack = 1'b0;
    cvj_smp_s       smp_in = '0;
    logic           awready, wready, bvalid, arready, rvalid, osr;
    logic [1:0]     bresp, rresp, dac_mute, adc_mute, r;
    logic [31:0]    rdata, d;
    cvj_smp_s       smp_out;
    cvj_gain_pair_s dac_gain, adc_gain;
    cvj_drv_s       drv;
    int             n_fail = 0;
    int             n_compared = 0;
    logic [7:0]     ra [6] = '{8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40};
    logic [8:0]     rv [6] = '{9'h0FF, 9'h0FF, 9'h000, 9'h100, 9'h0FF, 9'h0FF};
    logic [8:0]     ctl [2] = '{9'h002, 9'h009};
    logic [23:0]    el, er;

    always #50 clk = ~clk;

    cvj_regs u_cvj_regs (
        .CLK_SYS_I(clk), .RSTN_I(rstn), .AWADDR_I(awaddr),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
        .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready),
        .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(1'b1),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
        .RREADY_I(1'b1), .JACK_DET_I(jack), .ADC_SMP_I(smp_in),
        .ADC_SMP_O(smp_out), .DAC_GAIN_O(dac_gain), .ADC_GAIN_O(adc_gain),
        .DAC_MUTE_O(dac_mute), .ADC_MUTE_O(adc_mute), .DRV_EN_O(drv),
        .ADC_OSR128_O(osr)
    );

    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    // bready and rready stay high, so each response is taken at once
    // waits are unbounded; the watchdog alone ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        bit got_aw;
        bit got_w;
        got_aw = 0;
        got_w = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(got_aw && got_w)) begin
            @(posedge clk);
            if (awvalid === 1'b1 && awready === 1'b1) begin
                got_aw = 1;
                awvalid <= 1'b0;
            end
            if (wvalid === 1'b1 && wready === 1'b1) begin
                got_w = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        v = rdata;
        resp = rresp;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  rr;
        rd(a, v, rr);
        `CHK("readback", exp, v)
        `CHK("rresp", RESP_OKAY, rr)
    endtask

    task automatic print_verdict();
        $display("counts: n_fail=%0d n_compared=%0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) rchk(ra[i], {23'h0, rv[i]});
        wr(8'h2C, 32'h012, r);
        wr(8'h30, 32'h034, r);
        `CHK("dac_gain_staged", 16'hFFFF, dac_gain)
        wr(8'h30, 32'h134, r);
        `CHK("dac_gain_commit", 16'h1234, dac_gain)
        rchk(8'h30, 32'h034);
        wr(8'h2C, 32'h1AB, r);
        `CHK("dac_gain_left", 16'hAB34, dac_gain)
        wr(8'h30, 32'h100, r);
        repeat (2) @(posedge clk);
        `CHK("dac_mute", 2'b01, dac_mute)
        wr(8'h40, 32'h000, r);
        `CHK("adc_gain_staged", 16'hFFFF, adc_gain)
        wr(8'h3C, 32'h156, r);
        repeat (2) @(posedge clk);
        `CHK("adc_gain_commit", 16'h5600, adc_gain)
        `CHK("adc_mute", 2'b01, adc_mute)
        wr(8'h3C, 32'h001, r);
        `CHK("adc_gain_hold", 16'h5600, adc_gain)
        rchk(8'h3C, 32'h001);
        wr(8'h40, 32'h100, r);
        `CHK("adc_gain_right", 16'h0100, adc_gain)
        // map: low nibble hp+aux2, high nibble spk+aux1
        wr(8'h34, 32'h0A5, r);
        repeat (5) @(posedge clk);
        `CHK("drv_disabled", 4'h0, drv)
        wr(8'h80, 32'h001, r);
        repeat (5) @(posedge clk);
        `CHK("drv_low", 4'h5, drv)
        jack <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("drv_high", 4'hA, drv)
        // filter off so the sample path is a plain pass or negate
        for (int i = 0; i < 2; i++) begin
            wr(8'h38, {23'h0, ctl[i]}, r);
            `CHK("osr", ctl[i][OSR_BIT], osr)
            el = ctl[i][LINV_BIT] ? -24'h000010 : 24'h000010;
            er = ctl[i][RINV_BIT] ? -24'h000020 : 24'h000020;
            smp_in.valid <= 1'b1;
            smp_in.left <= 24'h000010;
            smp_in.right <= 24'h000020;
            @(posedge clk);
            smp_in.valid <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK("smp_left", el, smp_out.left)
            `CHK("smp_right", er, smp_out.right)
        end
        // highpass on, mode 1, fastest cutoff: steady dc must be blocked
        wr(8'h38, 32'h1F0, r);
        smp_in.valid <= 1'b1;
        smp_in.left <= 24'h100000;
        smp_in.right <= 24'h100000;
        repeat (600) @(posedge clk);
        smp_in.valid <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("hpf_left", 1'b1, smp_out.left <= 24'h000002)
        `CHK("hpf_right", 1'b1, smp_out.right <= 24'h000002)
        wr(8'h44, 32'h1FF, r);
        `CHK("bresp_unmapped", RESP_SLV, r)
        rd(8'h44, d, r);
        `CHK("rdata_unmapped", 32'h0, d)
        `CHK("rresp_unmapped", RESP_SLV, r)
        print_verdict();
    end

    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
endmodule // testbench
